// *** logic/cfh_map.svh ***
// offsets, field positions, reset values and counts of the card port
//
// Operation
// - IDE mode decodes only A2..A0
// - I/O mode: status-change line flags ready changes
// - battery and speaker lines high; WP low
// - CE2 odd byte; CE1 even/odd by A0
// - CS0 task file; CS1 alternate status/control
// - grounded cable select means master, open slave
// - IDE task bytes low lane; data 16-bit
// - I/O mode: input acknowledge on selected reads
// - DMA request handshake; undriven when unselected
// - I/O read strobe gates data, not memory
// - I/O write latches on trailing edge
// - OE reads memory data; I/O: config only
// - ready/busy low until initialisation completes
// - I/O interrupt active low; IDE active high
// - REG high common, low attribute memory
// - DMA acknowledge ignored while no DMA
// - RESET high resets PC modes; low IDE
// - wait output never asserted
// - WE writes memory and config; IDE ignores
// - 16-bit port indicator low on word ports
// - level bit 0 pulse, 1 level interrupt
`ifndef CFH_MAP_SVH
`define CFH_MAP_SVH

`define CFH_COR_ADDR 11'h200
`define CFH_CCSR_ADDR 11'h202
`define CFH_COR_SRESET 7
`define CFH_COR_LEVREQ 6
`define CFH_COR_INDEX_MSB 5
`define CFH_COR_RESET 8'h00
`define CFH_CCSR_CHANGED 5
`define CFH_CCSR_SIGCHG 4
`define CFH_CIS_FILL 8'hFF
`define CFH_DATA_IDX 3'h0
`define CFH_DEVHEAD_IDX 3'h6
`define CFH_CMD_IDX 3'h7
`define CFH_ALT_IDX 3'h6
`define CFH_DEV_BIT 4
`define CFH_NIEN_BIT 1
`define CFH_CTL_IDLE 10'h3FE
`define CFH_BUS_IDLE 27'h0000000
`define CFH_INIT_CYCLES 16
`define CFH_IRQ_PULSE 4

`endif

// *** logic/cfh_pkg.sv ***
// types shared by the card port
package cfh_pkg;
   typedef enum logic [1:0] {CFH_MEM, CFH_IO, CFH_IDE} cfh_mode_t;
   typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_GAP} cfh_dma_t;
endpackage

// *** logic/cfh_sync.sv ***
// three-stage pin synchroniser with agreement filter
module cfh_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] q
);
   import cfh_pkg::*;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         logic qb;
         always_ff @(posedge clk) begin
            if (srst) begin
               s1 <= INIT[i];
               s2 <= INIT[i];
               s3 <= INIT[i];
               qb <= INIT[i];
            end else if (ce) begin
               s1 <= pin[i];
               s2 <= s1;
               s3 <= s2;
               // change accepted once two stages agree
               if (s2 == s3) begin
                  qb <= s3;
               end
            end
         end
         assign q[i] = qb;
      end
   endgenerate
endmodule

// *** logic/cfh_lane.sv ***
// byte-lane steering from card enables and A2..A0
`include "cfh_map.svh"

module cfh_lane (
   input wire logic ide,
   input wire logic ce1_n,
   input wire logic ce2_n,
   input wire logic [2:0] a,
   output logic lo_en,
   output logic hi_en,
   output logic lo_odd,
   output logic [2:0] lo_idx,
   output logic [2:0] hi_idx
);
   import cfh_pkg::*;
   wire ide_one = ~ce1_n ^ ~ce2_n;
   wire ide_data = ~ce1_n & ce2_n & (a == `CFH_DATA_IDX);
   assign lo_odd = ~ide & ce2_n & a[0];
   assign lo_en = ide ? ide_one : ~ce1_n;
   assign hi_en = ide ? ide_data : ~ce2_n;
   assign lo_idx = ide ? a : {a[2:1], lo_odd};
   assign hi_idx = {a[2:1], 1'b1};
endmodule

// *** logic/cfh_port.sv ***
// host-facing pin logic of the removable flash card port
`include "cfh_map.svh"

module cfh_port #(
   parameter int INIT_CYCLES = `CFH_INIT_CYCLES,
   parameter int IRQ_PULSE = `CFH_IRQ_PULSE
) (
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic [10:0] A,
   input wire logic [15:0] D_IN,
   input wire logic CE1_N,
   input wire logic CE2_N,
   input wire logic OE_N,
   input wire logic WE_N,
   input wire logic IORD_N,
   input wire logic IOWR_N,
   input wire logic REG_N,
   input wire logic RESET,
   input wire logic CSEL_N,
   input wire logic DMACK_N,
   input wire logic CORE_BUSY,
   input wire logic CORE_IRQ,
   input wire logic CORE_DMA_REQ,
   input wire logic [15:0] DATA_RD,
   input wire logic [7:0] STATUS,
   output logic [15:0] D_OUT,
   output logic D_OE_LO,
   output logic D_OE_HI,
   output logic RDY_IRQ,
   output logic WIDTH16_N,
   output logic ACK_DMARQ,
   output logic ACK_DMARQ_OE,
   output logic WAIT_N,
   output logic CHG_N,
   output logic CHG_OE,
   output logic SPKR_N,
   output logic SPKR_OE,
   output logic [15:0] DATA_WR,
   output logic [1:0] DATA_WR_BE,
   output logic DATA_WR_STB,
   output logic DATA_RD_STB,
   output logic [7:0] CMD,
   output logic CMD_STB,
   output logic DMA_WORD_STB,
   output cfh_pkg::cfh_mode_t MODE,
   output logic IS_MASTER,
   output logic CARD_RESET
);
   import cfh_pkg::*;

   logic [9:0] ctl;
   logic [26:0] bus;
   logic ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, reg_n;
   logic csel_n, dmack_n, rst_pin;
   logic [10:0] a;
   logic [15:0] d_in;
   logic we_q, iowr_q, iord_q;
   logic ide_mode, init_done, cor_srst, cor_lvl, nien;
   logic [5:0] cor_index;
   logic sigchg_en, changed, rdy_q, irq_q, data_rd_q;
   logic [15:0] init_cnt;
   logic [7:0] pulse_cnt;
   logic [7:0] tf [0:7];
   logic lo_en, hi_en, lo_odd;
   logic [2:0] lo_idx, hi_idx;
   cfh_dma_t dma_state, next_dma_state;

   cfh_sync #(.W(10), .INIT(`CFH_CTL_IDLE)) u_ctl_sync (
      .clk(CLOCK),
      .srst(SRST),
      .ce(CE),
      .pin({CE1_N, CE2_N, OE_N, WE_N, IORD_N, IOWR_N, REG_N, CSEL_N,
            DMACK_N, RESET}),
      .q(ctl)
   );
   cfh_sync #(.W(27), .INIT(`CFH_BUS_IDLE)) u_bus_sync (
      .clk(CLOCK),
      .srst(SRST),
      .ce(CE),
      .pin({A, D_IN}),
      .q(bus)
   );
   assign {ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, reg_n} = ctl[9:3];
   assign {csel_n, dmack_n, rst_pin} = ctl[2:0];
   assign a = bus[26:16];
   assign d_in = bus[15:0];

   // strobe trailing edges
   wire we_rise = we_n & ~we_q;
   wire iowr_rise = iowr_n & ~iowr_q;
   wire iord_rise = iord_n & ~iord_q;

   // reset sources
   wire pin_rst = ide_mode ? ~rst_pin : rst_pin;
   wire hard_rst = SRST | pin_rst;
   wire card_rst = hard_rst | cor_srst;

   // interface mode
   wire is_ide = ide_mode;
   wire is_io = ~ide_mode & (cor_index != 6'h00);
   wire is_mem = ~ide_mode & (cor_index == 6'h00);
   wire cfh_mode_t mode_now = is_ide ? CFH_IDE : is_io ? CFH_IO : CFH_MEM;

   cfh_lane u_lane (
      .ide(is_ide),
      .ce1_n(ce1_n),
      .ce2_n(ce2_n),
      .a(a[2:0]),
      .lo_en(lo_en),
      .hi_en(hi_en),
      .lo_odd(lo_odd),
      .lo_idx(lo_idx),
      .hi_idx(hi_idx)
   );

   // address decode
   wire ce_any = ~ce1_n | ~ce2_n;
   wire ide_tf = ~ce1_n & ce2_n;
   wire ide_alt = ce1_n & ~ce2_n & (a[2:0] == `CFH_ALT_IDX);
   wire [10:0] attr_a = {a[10:1], 1'b0};
   wire cor_hit = attr_a == `CFH_COR_ADDR;
   wire ccsr_hit = attr_a == `CFH_CCSR_ADDR;
   wire data_acc = lo_en & (lo_idx == `CFH_DATA_IDX);
   wire dev_sel = tf[`CFH_DEVHEAD_IDX][`CFH_DEV_BIT] ^ IS_MASTER;

   // access qualification
   wire attr_rd = ~is_ide & ~reg_n & ~oe_n & ce_any;
   wire attr_wr = ~is_ide & ~reg_n & we_rise & lo_en & ~lo_odd;
   wire mem_rd = is_mem & reg_n & ~oe_n & ce_any;
   wire mem_wr = is_mem & reg_n & we_rise & ce_any;
   wire io_rd = is_io & ~reg_n & ~iord_n & ce_any;
   wire io_wr = is_io & ~reg_n & iowr_rise & ce_any;
   wire ide_rd = is_ide & ~iord_n & dmack_n;
   wire ide_wr = is_ide & iowr_rise & dmack_n;
   wire tf_rd = mem_rd | io_rd | (ide_rd & ide_tf);
   wire tf_wr = mem_wr | io_wr | (ide_wr & ide_tf);
   wire alt_rd = ide_rd & ide_alt;
   wire devctl_wr = ide_wr & ide_alt;
   wire cor_wr = attr_wr & cor_hit;
   wire ccsr_wr = attr_wr & ccsr_hit;

   // dma transfers, ignored outside an active request
   wire dma_live = dma_state != DMA_IDLE;
   wire dma_word = (dma_state == DMA_REQ) & ~dmack_n &
      (iord_rise | iowr_rise);
   wire dma_rd = dma_live & ~dmack_n & ~iord_n;

   // read data selection
   wire [7:0] lo_tf = (lo_idx == `CFH_CMD_IDX) ? STATUS : tf[lo_idx];
   wire [7:0] hi_tf = (hi_idx == `CFH_CMD_IDX) ? STATUS : tf[hi_idx];
   wire [7:0] lo_byte = data_acc ? DATA_RD[7:0] : lo_tf;
   wire [7:0] hi_byte = data_acc ? DATA_RD[15:8] : hi_tf;
   wire [7:0] ccsr_byte = (8'(changed) << `CFH_CCSR_CHANGED) |
      (8'(sigchg_en) << `CFH_CCSR_SIGCHG);
   wire [7:0] cor_byte = {cor_srst, cor_lvl, cor_index};
   wire [7:0] attr_byte = cor_hit ? cor_byte :
      ccsr_hit ? ccsr_byte : `CFH_CIS_FILL;
   wire [7:0] next_d_lo = dma_rd ? DATA_RD[7:0] :
      attr_rd ? attr_byte : alt_rd ? STATUS : lo_byte;
   wire [7:0] next_d_hi = dma_rd ? DATA_RD[15:8] :
      attr_rd ? `CFH_CIS_FILL : hi_byte;
   wire [15:0] next_d_out = {next_d_hi, next_d_lo};
   wire next_oe_lo = ((tf_rd | attr_rd) & lo_en) | alt_rd | dma_rd;
   wire next_oe_hi = ((tf_rd | attr_rd) & hi_en) | dma_rd;

   // write path
   wire [7:0] d_lo = d_in[7:0];
   wire [7:0] d_hi = d_in[15:8];
   wire cmd_lo = lo_en & (lo_idx == `CFH_CMD_IDX);
   wire cmd_hi = hi_en & (hi_idx == `CFH_CMD_IDX);
   wire next_cmd_stb = tf_wr & ~data_acc & (cmd_lo | cmd_hi);
   wire [7:0] next_cmd = cmd_lo ? d_lo : d_hi;
   wire next_wr_stb = (tf_wr & data_acc) | (dma_word & iowr_rise);
   wire [1:0] next_wr_be = dma_word ? 2'h3 : {hi_en, lo_en};
   wire data_rd_now = (tf_rd & data_acc) | dma_rd;
   wire next_rd_stb = data_rd_q & ~data_rd_now;

   // pin 37, 24, 43, 46, 45 levels
   wire ready = init_done & ~CORE_BUSY;
   wire io_irq = cor_lvl ? CORE_IRQ : (pulse_cnt != 8'h00);
   wire next_rdy_irq = is_ide ? (CORE_IRQ & ~nien) :
      is_io ? ~io_irq : ready;
   wire io_w16 = ce_any & ~reg_n &
      ((a[2:0] == `CFH_DATA_IDX) | (ce1_n & ~ce2_n));
   wire ide_w16 = ide_tf & (a[2:0] == `CFH_DATA_IDX) & dev_sel;
   wire next_w16_n = is_ide ? ~ide_w16 : is_io ? ~io_w16 : ~init_done;
   wire next_p43 = is_ide ? (dma_state == DMA_REQ) : ~io_rd;
   wire next_p43_oe = ~is_ide | dev_sel;
   wire next_chg_n = ~(is_io & sigchg_en & changed);

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         we_q <= 1'b1;
         iowr_q <= 1'b1;
         iord_q <= 1'b1;
      end else if (CE) begin
         we_q <= we_n;
         iowr_q <= iowr_n;
         iord_q <= iord_n;
      end
   end

   // mode and master/slave follow the pins until initialisation ends
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ide_mode <= 1'b0;
         IS_MASTER <= 1'b0;
      end else if (CE && !init_done) begin
         ide_mode <= ~oe_n;
         IS_MASTER <= ~csel_n;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (card_rst) begin
         init_cnt <= 16'h0000;
         init_done <= 1'b0;
      end else if (CE && !init_done) begin
         init_cnt <= init_cnt + 16'h0001;
         init_done <= init_cnt == 16'(INIT_CYCLES - 1);
      end
   end

   // soft reset bit survives its own reset
   always_ff @(posedge CLOCK) begin
      if (hard_rst) begin
         cor_srst <= 1'b0;
      end else if (CE && cor_wr) begin
         cor_srst <= d_lo[`CFH_COR_SRESET];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (card_rst) begin
         {cor_lvl, cor_index} <= 7'(`CFH_COR_RESET);
         sigchg_en <= 1'b0;
         nien <= 1'b0;
      end else if (CE) begin
         if (cor_wr) begin
            cor_lvl <= d_lo[`CFH_COR_LEVREQ];
            cor_index <= d_lo[`CFH_COR_INDEX_MSB:0];
         end
         if (ccsr_wr) begin
            sigchg_en <= d_lo[`CFH_CCSR_SIGCHG];
         end
         if (devctl_wr) begin
            nien <= d_lo[`CFH_NIEN_BIT];
         end
      end
   end

   // status change: a new ready edge wins over a clear
   always_ff @(posedge CLOCK) begin
      if (card_rst) begin
         changed <= 1'b0;
         rdy_q <= 1'b0;
         irq_q <= 1'b0;
         pulse_cnt <= 8'h00;
      end else if (CE) begin
         rdy_q <= ready;
         irq_q <= CORE_IRQ;
         if (is_io && (ready != rdy_q)) begin
            changed <= 1'b1;
         end else if (ccsr_wr && d_lo[`CFH_CCSR_CHANGED]) begin
            changed <= 1'b0;
         end
         if (is_io && !cor_lvl && CORE_IRQ && !irq_q) begin
            pulse_cnt <= 8'(IRQ_PULSE);
         end else if (pulse_cnt != 8'h00) begin
            pulse_cnt <= pulse_cnt - 8'h01;
         end
      end
   end

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_tf
         wire hit_lo = lo_en & (lo_idx == 3'(i));
         wire hit_hi = hi_en & (hi_idx == 3'(i));
         always_ff @(posedge CLOCK) begin
            if (card_rst) begin
               tf[i] <= 8'h00;
            end else if (CE && tf_wr && !data_acc) begin
               if (hit_lo) begin
                  tf[i] <= d_lo;
               end else if (hit_hi) begin
                  tf[i] <= d_hi;
               end
            end
         end
      end
   endgenerate

   always_comb begin
      next_dma_state = dma_state;
      unique case (dma_state)
         DMA_IDLE: begin
            if (is_ide && init_done && CORE_DMA_REQ && dev_sel) begin
               next_dma_state = DMA_REQ;
            end
         end
         DMA_REQ: begin
            if (dma_word) begin
               next_dma_state = DMA_GAP;
            end else if (!CORE_DMA_REQ && dmack_n) begin
               next_dma_state = DMA_IDLE;
            end
         end
         DMA_GAP: begin
            next_dma_state = CORE_DMA_REQ ? DMA_REQ : DMA_IDLE;
         end
         default: begin
            next_dma_state = DMA_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (card_rst) begin
         dma_state <= DMA_IDLE;
      end else if (CE) begin
         dma_state <= next_dma_state;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         D_OUT <= 16'h0000;
         D_OE_LO <= 1'b0;
         D_OE_HI <= 1'b0;
         RDY_IRQ <= 1'b0;
         WIDTH16_N <= 1'b1;
         ACK_DMARQ <= 1'b1;
         ACK_DMARQ_OE <= 1'b1;
         CHG_N <= 1'b1;
         CHG_OE <= 1'b1;
         SPKR_OE <= 1'b1;
         DATA_WR <= 16'h0000;
         DATA_WR_BE <= 2'h0;
         DATA_WR_STB <= 1'b0;
         DATA_RD_STB <= 1'b0;
         data_rd_q <= 1'b0;
         CMD <= 8'h00;
         CMD_STB <= 1'b0;
         DMA_WORD_STB <= 1'b0;
         MODE <= CFH_MEM;
         CARD_RESET <= 1'b1;
      end else if (CE) begin
         D_OUT <= next_d_out;
         D_OE_LO <= next_oe_lo;
         D_OE_HI <= next_oe_hi;
         RDY_IRQ <= next_rdy_irq;
         WIDTH16_N <= next_w16_n;
         ACK_DMARQ <= next_p43;
         ACK_DMARQ_OE <= next_p43_oe;
         CHG_N <= next_chg_n;
         CHG_OE <= ~is_ide;
         SPKR_OE <= ~is_ide;
         DATA_WR <= next_wr_stb ? d_in : DATA_WR;
         DATA_WR_BE <= next_wr_stb ? next_wr_be : DATA_WR_BE;
         DATA_WR_STB <= next_wr_stb;
         DATA_RD_STB <= next_rd_stb;
         data_rd_q <= data_rd_now;
         CMD <= next_cmd_stb ? next_cmd : CMD;
         CMD_STB <= next_cmd_stb;
         DMA_WORD_STB <= dma_word;
         MODE <= mode_now;
         CARD_RESET <= card_rst;
      end
   end

   // no battery, no audio, never a wait state
   always_ff @(posedge CLOCK) begin
      WAIT_N <= 1'b1;
      SPKR_N <= 1'b1;
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST || !CE);

   sequence s_pulse_start;
      is_io && !cor_lvl && CORE_IRQ && !irq_q;
   endsequence
   sequence s_pulse_low;
      ##2 (!RDY_IRQ) [*2];
   endsequence
   property p_irq_pulse;
      s_pulse_start |-> s_pulse_low;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("pulse interrupt not held low");
   property p_wait;
      ##1 (WAIT_N && SPKR_N);
   endproperty
   a_wait: assert property (p_wait)
      else $error("wait or speaker line asserted");
   property p_busy_init;
      is_mem && !init_done |=> !RDY_IRQ;
   endproperty
   a_busy_init: assert property (p_busy_init)
      else $error("ready shown before initialisation ends");
   property p_inpack;
      io_rd |=> !ACK_DMARQ && ACK_DMARQ_OE;
   endproperty
   a_inpack: assert property (p_inpack)
      else $error("input acknowledge missing on io read");
   property p_dmarq_float;
      is_ide && !dev_sel |=> !ACK_DMARQ_OE;
   endproperty
   a_dmarq_float: assert property (p_dmarq_float)
      else $error("dma request driven while unselected");
   property p_dmack_ignored;
      dma_state == DMA_IDLE |=> !DMA_WORD_STB;
   endproperty
   a_dmack_ignored: assert property (p_dmack_ignored)
      else $error("dma word taken with no dma active");
   property p_iowr_edge;
      io_wr && data_acc |=> DATA_WR_STB && DATA_WR == $past(d_in);
   endproperty
   a_iowr_edge: assert property (p_iowr_edge)
      else $error("io write not latched on trailing edge");
   property p_pin_reset;
      (is_ide ? !rst_pin : rst_pin) |=> CARD_RESET;
   endproperty
   a_pin_reset: assert property (p_pin_reset)
      else $error("reset pin did not reset the card");
   property p_mode_hold;
      init_done && $past(init_done) |-> $stable(ide_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed outside reset");
   property p_iocs16;
      is_ide && ide_w16 |=> !WIDTH16_N;
   endproperty
   a_iocs16: assert property (p_iocs16)
      else $error("word transfer indicator not low");
endmodule

// *** tb/cfh_host.sv ***
// host socket model: drives card pins, records what comes back
module cfh_host (
   input wire logic clk,
   input wire logic [15:0] d_out,
   input wire logic d_oe_lo,
   input wire logic d_oe_hi,
   input wire logic ack_n,
   input wire logic w16_n,
   input wire logic wr_stb,
   input wire logic cmd_stb,
   input wire logic dma_stb,
   output logic [10:0] a,
   output logic [15:0] d_in,
   output logic ce1_n,
   output logic ce2_n,
   output logic oe_n,
   output logic we_n,
   output logic iord_n,
   output logic iowr_n,
   output logic reg_n,
   output logic reset,
   output logic csel_n,
   output logic dmack_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic oe_idle = 1'b1;
   logic [15:0] rd_data;
   logic [1:0] rd_oe;
   logic [1:0] rd_pins;
   int rd_cnt;
   int wr_cnt = 0;
   int cmd_cnt = 0;
   int dma_cnt = 0;
   initial begin
      a = 11'h000;
      d_in = 16'h0000;
      {dmack_n, reg_n, ce2_n, ce1_n} = 4'hF;
      {we_n, oe_n, iowr_n, iord_n} = 4'hF;
      reset = 1'b0;
      csel_n = 1'b1;
   end
   always @(posedge clk) begin
      wr_cnt <= wr_cnt + int'(wr_stb);
      cmd_cnt <= cmd_cnt + int'(cmd_stb);
      dma_cnt <= dma_cnt + int'(dma_stb);
   end
   // kind 0 io read, 1 io write, 2 attr read, 3 attr write, 4 dma read
   // kind 6 common memory read
   task automatic cyc(input int kind, input logic [1:0] ce_n,
         input logic [10:0] addr, input logic [15:0] data);
      @(negedge clk);
      a = addr;
      {ce2_n, ce1_n} = ce_n;
      reg_n = (kind > 4);
      dmack_n = (kind != 4);
      d_in = kind[0] ? data : ~d_in;
      repeat (6) @(negedge clk);
      {we_n, oe_n, iowr_n, iord_n} = ~(4'h1 << (kind % 4))
         & {1'b1, oe_idle, 2'b11};
      repeat (8) @(negedge clk);
      rd_data = d_out;
      rd_oe = {d_oe_hi, d_oe_lo};
      rd_pins = {ack_n, w16_n};
      rd_cnt = wr_cnt;
      {we_n, oe_n, iowr_n, iord_n} = {1'b1, oe_idle, 2'b11};
      repeat (6) @(negedge clk);
      {dmack_n, reg_n, ce2_n, ce1_n} = 4'hF;
      d_in = ~d_in;
      repeat (4) @(negedge clk);
   endtask
endmodule

// *** tb/cfh_port_tb.sv ***
// self-checking bench of the card port
module cfh_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cfh_pkg::*;
   logic CLOCK = 1'b0;
   logic SRST = 1'b1;
   logic CORE_BUSY = 1'b0;
   logic CORE_IRQ = 1'b0;
   logic CORE_DMA_REQ = 1'b0;
   logic [15:0] DATA_RD = 16'h0000;
   logic [7:0] STATUS = 8'h00;
   logic [10:0] A;
   logic [15:0] D_IN, D_OUT, DATA_WR;
   logic CE1_N, CE2_N, OE_N, WE_N, IORD_N, IOWR_N, REG_N, RESET;
   logic CSEL_N, DMACK_N, D_OE_LO, D_OE_HI, RDY_IRQ, WIDTH16_N;
   logic ACK_DMARQ, ACK_DMARQ_OE, WAIT_N, CHG_N, CHG_OE, SPKR_N;
   logic SPKR_OE, DATA_WR_STB, DATA_RD_STB, CMD_STB, DMA_WORD_STB;
   logic IS_MASTER, CARD_RESET;
   logic [1:0] DATA_WR_BE;
   logic [7:0] CMD;
   cfh_mode_t MODE;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   int rd_stbs = 0;
   int n;
   cfh_port #(.INIT_CYCLES(6), .IRQ_PULSE(4)) u_dut (
      .CLOCK(CLOCK), .SRST(SRST), .CE(1'b1), .A(A), .D_IN(D_IN),
      .CE1_N(CE1_N), .CE2_N(CE2_N), .OE_N(OE_N), .WE_N(WE_N),
      .IORD_N(IORD_N), .IOWR_N(IOWR_N), .REG_N(REG_N), .RESET(RESET),
      .CSEL_N(CSEL_N), .DMACK_N(DMACK_N), .CORE_BUSY(CORE_BUSY),
      .CORE_IRQ(CORE_IRQ), .CORE_DMA_REQ(CORE_DMA_REQ),
      .DATA_RD(DATA_RD), .STATUS(STATUS), .D_OUT(D_OUT),
      .D_OE_LO(D_OE_LO), .D_OE_HI(D_OE_HI), .RDY_IRQ(RDY_IRQ),
      .WIDTH16_N(WIDTH16_N), .ACK_DMARQ(ACK_DMARQ),
      .ACK_DMARQ_OE(ACK_DMARQ_OE), .WAIT_N(WAIT_N), .CHG_N(CHG_N),
      .CHG_OE(CHG_OE), .SPKR_N(SPKR_N), .SPKR_OE(SPKR_OE),
      .DATA_WR(DATA_WR), .DATA_WR_BE(DATA_WR_BE),
      .DATA_WR_STB(DATA_WR_STB), .DATA_RD_STB(DATA_RD_STB),
      .CMD(CMD), .CMD_STB(CMD_STB), .DMA_WORD_STB(DMA_WORD_STB),
      .MODE(MODE), .IS_MASTER(IS_MASTER), .CARD_RESET(CARD_RESET));
   cfh_host u_host (
      .clk(CLOCK), .d_out(D_OUT), .d_oe_lo(D_OE_LO),
      .d_oe_hi(D_OE_HI), .ack_n(ACK_DMARQ), .w16_n(WIDTH16_N),
      .wr_stb(DATA_WR_STB), .cmd_stb(CMD_STB), .dma_stb(DMA_WORD_STB),
      .a(A), .d_in(D_IN), .ce1_n(CE1_N), .ce2_n(CE2_N), .oe_n(OE_N),
      .we_n(WE_N), .iord_n(IORD_N), .iowr_n(IOWR_N), .reg_n(REG_N),
      .reset(RESET), .csel_n(CSEL_N), .dmack_n(DMACK_N));
   initial begin
      forever #10 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      rd_stbs <= rd_stbs + int'(DATA_RD_STB);
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic do_reset(input logic ide, input logic master);
      @(negedge CLOCK);
      SRST = 1'b1;
      u_host.oe_idle = ~ide;
      u_host.oe_n = ~ide;
      u_host.reset = ide;
      u_host.csel_n = ~master;
      repeat (16) @(negedge CLOCK);
      SRST = 1'b0;
      repeat (2) @(negedge CLOCK);
      chk(16'(RDY_IRQ), 16'h0000);
      repeat (50) @(negedge CLOCK);
   endtask
   task automatic t_mem();
      do_reset(1'b0, 1'b0);
      chk(16'(MODE), 16'(CFH_MEM));
      chk(16'(RDY_IRQ), 16'h0001);
      chk(16'({WIDTH16_N, CHG_N, SPKR_N}), 16'h0003);
      chk(16'(WAIT_N), 16'h0001);
      u_host.cyc(0, 2'b00, 11'h000, 16'h0000);
      chk(16'(u_host.rd_oe), 16'h0000);
      DATA_RD = 16'h1234;
      u_host.cyc(6, 2'b00, 11'h000, 16'h0000);
      chk(u_host.rd_data, 16'h1234);
      u_host.cyc(2, 2'b10, 11'h200, 16'h0000);
      chk(u_host.rd_data & 16'h00FF, 16'h0000);
      chk(16'(u_host.rd_oe), 16'h0001);
      u_host.cyc(2, 2'b10, 11'h002, 16'h0000);
      chk(u_host.rd_data & 16'h00FF, 16'h00FF);
      u_host.cyc(3, 2'b10, 11'h200, 16'h0041);
      chk(16'(MODE), 16'(CFH_IO));
      $display("memory mode test done");
   endtask
   task automatic t_io();
      n = u_host.wr_cnt;
      u_host.cyc(1, 2'b00, 11'h000, 16'hA55A);
      chk(16'(u_host.rd_cnt - n), 16'h0000);
      chk(16'(u_host.wr_cnt - n), 16'h0001);
      chk(DATA_WR, 16'hA55A);
      chk(16'(DATA_WR_BE), 16'h0003);
      DATA_RD = 16'h1234;
      n = rd_stbs;
      u_host.cyc(0, 2'b00, 11'h000, 16'h0000);
      chk(u_host.rd_data, 16'h1234);
      chk(16'(rd_stbs - n), 16'h0001);
      chk(16'(u_host.rd_oe), 16'h0003);
      chk(16'(u_host.rd_pins), 16'h0000);
      u_host.cyc(0, 2'b01, 11'h001, 16'h0000);
      chk(16'(u_host.rd_oe), 16'h0002);
      u_host.cyc(0, 2'b11, 11'h000, 16'h0000);
      chk(16'({u_host.rd_oe, u_host.rd_pins[1]}), 16'h0001);
      u_host.cyc(3, 2'b10, 11'h202, 16'h0010);
      CORE_BUSY = 1'b1;
      repeat (12) @(negedge CLOCK);
      chk(16'(CHG_N), 16'h0000);
      $display("io mode test done");
   endtask
   task automatic t_irq();
      CORE_IRQ = 1'b1;
      repeat (10) @(negedge CLOCK);
      chk(16'(RDY_IRQ), 16'h0000);
      CORE_IRQ = 1'b0;
      repeat (10) @(negedge CLOCK);
      chk(16'(RDY_IRQ), 16'h0001);
      u_host.cyc(3, 2'b10, 11'h200, 16'h0001);
      CORE_IRQ = 1'b1;
      n = 0;
      repeat (20) @(negedge CLOCK) n += int'(!RDY_IRQ);
      chk(16'(n), 16'h0004);
      CORE_IRQ = 1'b0;
      u_host.cyc(3, 2'b10, 11'h200, 16'h0080);
      chk(16'(CARD_RESET), 16'h0001);
      $display("interrupt test done");
   endtask
   task automatic t_ide();
      do_reset(1'b1, 1'b1);
      chk(16'(MODE), 16'(CFH_IDE));
      chk(16'(IS_MASTER), 16'h0001);
      STATUS = 8'h5A;
      u_host.cyc(0, 2'b10, 11'h007, 16'h0000);
      chk({u_host.rd_data[7:0], 6'h0, u_host.rd_oe}, 16'h5A01);
      u_host.cyc(0, 2'b01, 11'h006, 16'h0000);
      chk({u_host.rd_data[7:0], 6'h0, u_host.rd_oe}, 16'h5A01);
      u_host.cyc(0, 2'b10, 11'h000, 16'h0000);
      chk(16'({u_host.rd_oe, u_host.rd_pins[0]}), 16'h0006);
      n = u_host.cmd_cnt;
      u_host.cyc(1, 2'b10, 11'h007, 16'h00EC);
      u_host.cyc(1, 2'b00, 11'h007, 16'h0011);
      chk(16'(u_host.cmd_cnt - n), 16'h0001);
      chk(16'(CMD), 16'h00EC);
      n = u_host.dma_cnt;
      u_host.cyc(4, 2'b11, 11'h000, 16'h0000);
      chk(16'(u_host.dma_cnt - n), 16'h0000);
      u_host.cyc(1, 2'b10, 11'h006, 16'h0010);
      CORE_DMA_REQ = 1'b1;
      repeat (10) @(negedge CLOCK);
      chk(16'(ACK_DMARQ_OE), 16'h0000);
      u_host.cyc(1, 2'b10, 11'h006, 16'h0000);
      chk(16'({ACK_DMARQ, ACK_DMARQ_OE}), 16'h0003);
      u_host.cyc(4, 2'b11, 11'h000, 16'h0000);
      chk(16'(u_host.dma_cnt - n), 16'h0001);
      CORE_DMA_REQ = 1'b0;
      CORE_IRQ = 1'b1;
      repeat (10) @(negedge CLOCK);
      chk(16'({RDY_IRQ, CHG_OE, SPKR_OE}), 16'h0004);
      u_host.reset = 1'b0;
      repeat (10) @(negedge CLOCK);
      chk(16'(CARD_RESET), 16'h0001);
      $display("ide mode test done");
   endtask
   initial begin
      t_mem();
      t_io();
      t_irq();
      t_ide();
      give_verdict();
   end
endmodule
